//--- src/atdp_pkg.sv
// Shared constants, types and timing for the parallel disk host port
// Operation
// - Host answers DMARQ with DMACK
// - DIOR reads, DIOW writes in multiword
// - Host holds HDMARDY while accepting read data
// - Data valid on both HSTROBE edges
// - Host pauses write by holding HSTROBE
// - STOP asserted before burst, dropped before data
// - STOP during burst ends the burst
// - PIO cycle, pulse, recovery minimum times
// - Multiword cycle, pulse, negated minimum times
// - Ultra modes 0 to 4 strobe spacing
// - DMACK switches pins to Ultra meanings
package atdp_pkg;

  localparam int LINK_PERIOD_NS = 64;
  localparam int CORE_PERIOD_NS = 50;
  localparam int SYNC_LAT       = 2;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / LINK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  localparam int PIO_T0_NS    = 120;
  localparam int PIO_T1_NS    = 25;
  localparam int PIO_T2_NS    = 70;
  localparam int PIO_T2I_NS   = 25;
  localparam int PIO_SLOW_NS  = 240;
  localparam int IORDY_MAX_NS = 1250;
  localparam int MW_T0_NS     = 120;
  localparam int MW_TD_NS     = 70;
  localparam int MW_TK_NS     = 25;
  localparam int RESET_LOW_S  = 25;
  localparam int BUSY_MAX_S   = 31;
  localparam int UDMA_TCYC_NS [0:4] = '{112, 73, 54, 39, 25};

  localparam int PIO_REC_NS = (PIO_T2I_NS > PIO_T0_NS - PIO_T2_NS) ? PIO_T2I_NS : PIO_T0_NS - PIO_T2_NS;
  localparam int MW_REC_NS  = (MW_TK_NS > MW_T0_NS - MW_TD_NS) ? MW_TK_NS : MW_T0_NS - MW_TD_NS;

  localparam logic [31:0] PIO_T1_CYC    = 32'(cyc_min(PIO_T1_NS));
  localparam logic [31:0] PIO_STB_CYC   = 32'(cyc_min(PIO_T2_NS) + SYNC_LAT);
  localparam logic [31:0] PIO_REC_CYC   = 32'(cyc_min(PIO_REC_NS));
  localparam logic [31:0] IORDY_TMO_CYC = 32'(cyc_max(IORDY_MAX_NS) + cyc_min(PIO_T2_NS) + SYNC_LAT);
  localparam logic [31:0] MW_STB_CYC    = 32'(cyc_min(MW_TD_NS) + SYNC_LAT);
  localparam logic [31:0] MW_REC_CYC    = 32'(cyc_min(MW_REC_NS));
  localparam logic [31:0] RESET_LOW_CYC = 32'((64'(RESET_LOW_S) * 64'd1000000000 + 64'(LINK_PERIOD_NS) - 64'd1)
                                              / 64'(LINK_PERIOD_NS));

  function automatic logic [31:0] udma_cyc(input logic [2:0] mode);
    return 32'(cyc_min(UDMA_TCYC_NS[(mode > 3'h4) ? 3'h4 : mode]));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    OP_RESET  = 3'h0,
    OP_PIO_RD = 3'h1,
    OP_PIO_WR = 3'h2,
    OP_MW_RD  = 3'h3,
    OP_MW_WR  = 3'h4,
    OP_UD_RD  = 3'h5,
    OP_UD_WR  = 3'h6
  } atdp_op_e;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_PSET  = 4'h1,
    ST_PACT  = 4'h3,
    ST_PREC  = 4'h2,
    ST_DONE  = 4'h6,
    ST_DREQ  = 4'h7,
    ST_MW    = 4'h5,
    ST_MWACT = 4'h4,
    ST_MWNEG = 4'hC,
    ST_UGO   = 4'hD,
    ST_URD   = 4'hF,
    ST_UWR   = 4'hE,
    ST_UEND  = 4'hA,
    ST_RST   = 4'hB
  } atdp_state_e;

  typedef struct packed {
    atdp_op_e    op;
    logic [2:0]  mode;
    logic [1:0]  cs_n;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic [15:0] len;
  } atdp_cmd_s;

  typedef struct packed {
    logic        reset_n;
    logic [1:0]  cs_n;
    logic [2:0]  da;
    logic        dior_n;
    logic        diow_n;
    logic        dmack_n;
    logic [15:0] dd;
    logic        dd_oe;
  } atdp_pins_s;

  localparam atdp_pins_s PINS_IDLE = '{reset_n: 1'h1, cs_n: 2'h3, da: 3'h0, dior_n: 1'h1, diow_n: 1'h1,
                                       dmack_n: 1'h1, dd: 16'h0000, dd_oe: 1'h0};

endpackage

//--- src/atdp_sync.sv
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module atdp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end

endmodule

//--- src/atdp_host.sv
// Host controller for the parallel disk port: PIO, multiword and Ultra DMA
`timescale 1ns/1ps
module atdp_host
  import atdp_pkg::*;
#(
  parameter logic [31:0] RESET_CYC = RESET_LOW_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        link_clk,
  input  wire logic        cmd_valid,
  input  wire atdp_cmd_s   cmd,
  output logic             cmd_ready,
  output logic             done,
  output logic [15:0]      done_rdata,
  output logic             done_timeout,
  input  wire logic        wr_valid,
  input  wire logic [15:0] wr_data,
  output logic             wr_ready,
  output logic             rd_valid,
  output logic [15:0]      rd_data,
  output atdp_pins_s       pins,
  input  wire logic        iordy_i,
  input  wire logic        dmarq_i,
  input  wire logic [15:0] dd_i
);

  // Core side handshake state
  atdp_cmd_s   cmd_q;
  logic        cmd_tog;
  logic        done_seen;
  logic [15:0] wr_q;
  logic        wr_tog;
  logic        wr_seen;
  logic        rd_seen;
  logic        rd_ack_tog;
  logic [2:0]  c_sync;

  // Link side state
  logic        l_rstn;
  logic [2:0]  l_sync;
  logic [17:0] pin_s;
  atdp_state_e st;
  atdp_cmd_s   l_cmd;
  logic        cmd_seen;
  logic        l_done_tog;
  logic [15:0] l_rdata;
  logic        l_tmo;
  logic        l_wr_ack;
  logic        l_rd_tog;
  logic [15:0] l_rd_q;
  logic [31:0] tmr;
  logic [15:0] left;
  logic        pend;
  logic        iordy_d;
  logic        iordy_s;
  logic        dmarq_s;
  logic [15:0] dd_s;
  logic        rd_free;
  logic        wr_avail;
  logic        is_rd;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings
  atdp_sync #(.W(3)) u_csync (
    .clk (core_clk),
    .d   ({l_done_tog, l_wr_ack, l_rd_tog}),
    .q   (c_sync)
  );

  atdp_sync #(.W(1)) u_lrst (
    .clk (link_clk),
    .d   (rstn),
    .q   (l_rstn)
  );

  atdp_sync #(.W(3)) u_lsync (
    .clk (link_clk),
    .d   ({cmd_tog, wr_tog, rd_ack_tog}),
    .q   (l_sync)
  );

  atdp_sync #(.W(18)) u_pins (
    .clk (link_clk),
    .d   ({iordy_i, dmarq_i, dd_i}),
    .q   (pin_s)
  );

  assign iordy_s  = pin_s[17];
  assign dmarq_s  = pin_s[16];
  assign dd_s     = pin_s[15:0];
  assign rd_free  = (l_sync[0] == l_rd_tog);
  assign wr_avail = (l_sync[1] != l_wr_ack);
  assign is_rd    = (l_cmd.op == OP_PIO_RD) || (l_cmd.op == OP_MW_RD) || (l_cmd.op == OP_UD_RD);

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: command and completion
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cmd_q        <= '0;
      cmd_tog      <= 1'h0;
      cmd_ready    <= 1'h1;
      done_seen    <= 1'h0;
      done         <= 1'h0;
      done_rdata   <= 16'h0000;
      done_timeout <= 1'h0;
    end else begin
      done <= 1'h0;
      if (cmd_valid && cmd_ready) begin
        cmd_q     <= cmd;
        cmd_tog   <= ~cmd_tog;
        cmd_ready <= 1'h0;
      end
      if (c_sync[2] != done_seen) begin
        done_seen    <= c_sync[2];
        done         <= 1'h1;
        done_rdata   <= l_rdata;
        done_timeout <= l_tmo;
        cmd_ready    <= 1'h1;
      end
    end
  end

  // Core domain: write words toward the link
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      wr_q     <= 16'h0000;
      wr_tog   <= 1'h0;
      wr_seen  <= 1'h0;
      wr_ready <= 1'h1;
    end else begin
      if (wr_valid && wr_ready) begin
        wr_q     <= wr_data;
        wr_tog   <= ~wr_tog;
        wr_ready <= 1'h0;
      end
      if (c_sync[1] != wr_seen) begin
        wr_seen  <= c_sync[1];
        wr_ready <= 1'h1;
      end
    end
  end

  // Core domain: read words from the link
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rd_seen    <= 1'h0;
      rd_ack_tog <= 1'h0;
      rd_valid   <= 1'h0;
      rd_data    <= 16'h0000;
    end else begin
      rd_valid <= 1'h0;
      if (c_sync[0] != rd_seen) begin
        rd_seen    <= c_sync[0];
        rd_ack_tog <= ~rd_ack_tog;
        rd_valid   <= 1'h1;
        rd_data    <= l_rd_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: strobe edge detect
  always_ff @(posedge link_clk) begin
    if (!l_rstn) begin
      iordy_d <= 1'h1;
    end else begin
      iordy_d <= iordy_s;
    end
  end

  // Link domain: bus cycle sequencer and pin drive
  always_ff @(posedge link_clk) begin
    if (!l_rstn) begin
      st         <= ST_IDLE;
      pins       <= PINS_IDLE;
      l_cmd      <= '0;
      cmd_seen   <= 1'h0;
      l_done_tog <= 1'h0;
      l_rdata    <= 16'h0000;
      l_tmo      <= 1'h0;
      l_wr_ack   <= 1'h0;
      l_rd_tog   <= 1'h0;
      l_rd_q     <= 16'h0000;
      tmr        <= 32'h0;
      left       <= 16'h0000;
      pend       <= 1'h0;
    end else begin
      tmr <= tmr + 32'h1;
      case (st)
        ST_IDLE: begin
          tmr <= 32'h0;
          if (l_sync[2] != cmd_seen) begin
            cmd_seen <= l_sync[2];
            l_cmd    <= cmd_q;
            l_tmo    <= 1'h0;
            l_rdata  <= 16'h0000;
            left     <= cmd_q.len;
            pend     <= 1'h0;
            if (cmd_q.op == OP_RESET) begin
              pins.reset_n <= 1'h0;
              st           <= ST_RST;
            end else if (cmd_q.op == OP_PIO_RD || cmd_q.op == OP_PIO_WR) begin
              pins.cs_n  <= cmd_q.cs_n;
              pins.da    <= cmd_q.addr;
              pins.dd    <= cmd_q.wdata;
              pins.dd_oe <= (cmd_q.op == OP_PIO_WR);
              st         <= ST_PSET;
            end else begin
              st <= ST_DREQ;
            end
          end
        end
        ST_RST: begin
          if (tmr >= RESET_CYC - 32'h1) begin
            pins.reset_n <= 1'h1;
            st           <= ST_DONE;
          end
        end
        ST_PSET: begin
          if (tmr >= PIO_T1_CYC - 32'h1) begin
            pins.dior_n <= ~is_rd;
            pins.diow_n <= is_rd;
            tmr         <= 32'h0;
            st          <= ST_PACT;
          end
        end
        ST_PACT: begin
          if ((tmr >= PIO_STB_CYC - 32'h1 && iordy_s) || tmr >= IORDY_TMO_CYC) begin
            l_tmo       <= ~iordy_s;
            l_rdata     <= is_rd ? dd_s : 16'h0000;
            pins.dior_n <= 1'h1;
            pins.diow_n <= 1'h1;
            tmr         <= 32'h0;
            st          <= ST_PREC;
          end
        end
        ST_PREC: begin
          if (tmr >= PIO_REC_CYC - 32'h1) begin
            st <= ST_DONE;
          end
        end
        ST_DONE: begin
          pins       <= PINS_IDLE;
          l_done_tog <= ~l_done_tog;
          st         <= ST_IDLE;
        end
        ST_DREQ: begin
          tmr <= 32'h0;
          if (left == 16'h0000) begin
            st <= ST_DONE;
          end else if (dmarq_s) begin
            pins.dmack_n <= 1'h0;
            pins.diow_n  <= 1'h1;
            pins.dior_n  <= 1'h1;
            st <= (l_cmd.op == OP_UD_RD || l_cmd.op == OP_UD_WR) ? ST_UGO : ST_MW;
          end
        end
        ST_MW: begin
          tmr <= 32'h0;
          if (!dmarq_s) begin
            pins.dmack_n <= 1'h1;
            st           <= ST_DREQ;
          end else if (is_rd && rd_free) begin
            pins.dior_n <= 1'h0;
            st          <= ST_MWACT;
          end else if (!is_rd && wr_avail) begin
            pins.dd     <= wr_q;
            pins.dd_oe  <= 1'h1;
            pins.diow_n <= 1'h0;
            l_wr_ack    <= ~l_wr_ack;
            st          <= ST_MWACT;
          end
        end
        ST_MWACT: begin
          if (tmr >= MW_STB_CYC - 32'h1) begin
            pins.dior_n <= 1'h1;
            pins.diow_n <= 1'h1;
            if (is_rd) begin
              l_rd_q   <= dd_s;
              l_rd_tog <= ~l_rd_tog;
            end
            left <= left - 16'h0001;
            tmr  <= 32'h0;
            st   <= ST_MWNEG;
          end
        end
        ST_MWNEG: begin
          if (tmr >= MW_REC_CYC - 32'h1) begin
            pins.dd_oe <= 1'h0;
            if (left == 16'h0000) begin
              pins.dmack_n <= 1'h1;
              st           <= ST_DONE;
            end else begin
              st <= ST_MW;
            end
          end
        end
        ST_UGO: begin
          tmr         <= 32'h0;
          pins.diow_n <= 1'h0;
          if (is_rd) begin
            pins.dior_n <= ~rd_free;
            st          <= ST_URD;
          end else begin
            pins.dd_oe <= 1'h1;
            st         <= ST_UWR;
          end
        end
        ST_URD: begin
          if (!dmarq_s || left == 16'h0000) begin
            pins.diow_n <= 1'h1;
            pins.dior_n <= 1'h1;
            st          <= ST_UEND;
          end else if (iordy_s != iordy_d) begin
            if (rd_free) begin
              l_rd_q   <= dd_s;
              l_rd_tog <= ~l_rd_tog;
              left     <= left - 16'h0001;
            end
            pins.dior_n <= 1'h1;
          end else begin
            pins.dior_n <= ~rd_free;
          end
        end
        ST_UWR: begin
          if (!dmarq_s || (left == 16'h0000 && !pend)) begin
            pins.diow_n <= 1'h1;
            st          <= ST_UEND;
          end else if (pend && !iordy_s && tmr >= udma_cyc(l_cmd.mode) - 32'h1) begin
            pins.dior_n <= ~pins.dior_n;
            pend        <= 1'h0;
            left        <= left - 16'h0001;
            tmr         <= 32'h0;
          end else if (!pend && wr_avail && left != 16'h0000) begin
            pins.dd  <= wr_q;
            l_wr_ack <= ~l_wr_ack;
            pend     <= 1'h1;
          end
        end
        ST_UEND: begin
          if (!dmarq_s) begin
            pins.dmack_n <= 1'h1;
            pins.dior_n  <= 1'h1;
            pins.diow_n  <= 1'h1;
            pins.dd_oe   <= 1'h0;
            st           <= ST_DONE;
          end
        end
        default: begin
          pins <= PINS_IDLE;
          st   <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

//--- bench/atdp_host_properties.sv
// Checker for the host port handshakes
`timescale 1ns/1ps
module atdp_host_properties
  import atdp_pkg::*;
#(
  parameter logic [31:0] RESET_CYC = 32'h8
) (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       link_clk,
  input wire logic       done,
  input wire logic       rd_valid,
  input wire atdp_pins_s pins,
  input wire logic       dmarq_i
);
  done_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    done |=> !done) else $error("done longer than one cycle");
  rd_pulse_a: assert property (@(posedge core_clk) disable iff (!rstn)
    rd_valid |=> !rd_valid) else $error("rd_valid longer than one cycle");
  pio_width_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(pins.dior_n) && pins.dmack_n |-> (!pins.dior_n) [*4]) else $error("read strobe too short");
  pio_wait_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(pins.dior_n) && pins.dmack_n |-> ##[1:26] pins.dior_n) else $error("read strobe never ends");
  pio_setup_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(pins.dior_n && pins.diow_n) && pins.dmack_n |-> $past(pins.cs_n) != 2'h3)
    else $error("strobe without select setup");
  pio_dir_a: assert property (@(posedge link_clk) disable iff (!rstn)
    pins.dmack_n && (pins.dior_n != pins.diow_n) |-> pins.dd_oe == pins.dior_n)
    else $error("data drive against direction");
  dmack_req_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $fell(pins.dmack_n) |-> $past(dmarq_i, 3)) else $error("acknowledge without request");
  ack_release_a: assert property (@(posedge link_clk) disable iff (!rstn)
    $rose(pins.dmack_n) |-> ##[0:2] !pins.dd_oe) else $error("data bus held after burst");
  cover property (@(posedge link_clk) $fell(pins.dmack_n));
  cover property (@(posedge core_clk) rd_valid);
  cover property (@(posedge core_clk) done);
endmodule

bind atdp_host atdp_host_properties #(.RESET_CYC(RESET_CYC)) i_atdp_host_properties (
  .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .done(done),
  .rd_valid(rd_valid), .pins(pins), .dmarq_i(dmarq_i));

//--- bench/atdp_dev_model.sv
// Behavioural disk device on the far side of the pins
`timescale 1ns/1ps
module atdp_dev_model
  import atdp_pkg::*;
(
  input  wire logic        link_clk,
  input  wire atdp_pins_s  pins,
  input  wire logic [15:0] dd_w,
  input  wire logic        udma,
  input  wire logic        rd,
  input  wire logic        dreq,
  input  wire logic [7:0]  slow,
  output logic             iordy,
  output logic             dmarq,
  output logic [15:0]      dev_dd
);
  logic [15:0] wreg    = 16'h0000;
  logic [15:0] k       = 16'h0000;
  logic [2:0]  ph      = 3'h0;
  logic        dstb    = 1'h1;
  logic        pio_rdy = 1'h1;
  logic        stopped = 1'h0;
  logic [7:0]  gap      = 8'h00;
  logic        ack_d    = 1'h1;
  logic [3:0]  busy_cnt = 4'h0;
  logic        dev_num;
  logic [15:0] cap [$];
  // Strap tied to ground; this host never polls status after a block
  localparam logic CSEL_GND   = 1'h1;
  localparam int   WR_GAP_CYC = (3800 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  localparam int   RD_GAP_CYC = (4200 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
  assign dev_num = !CSEL_GND;
  initial dev_dd = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////
  assign dmarq = dreq && !stopped && gap == 8'h00 && busy_cnt == 4'h0;
  // Busy after the reset pin, request gap after each block
  always @(posedge link_clk) begin
    ack_d <= pins.dmack_n;
    if (!pins.reset_n)
      busy_cnt <= 4'hF;
    else if (busy_cnt != 4'h0)
      busy_cnt <= busy_cnt - 4'h1;
    if (pins.dmack_n && !ack_d)
      gap <= 8'(rd ? RD_GAP_CYC : WR_GAP_CYC);
    else if (gap != 8'h00)
      gap <= gap - 8'h01;
  end
  assign iordy = (udma && !pins.dmack_n) ? (rd ? dstb : 1'h0) : pio_rdy;
  always @(negedge pins.dior_n or negedge pins.diow_n) begin
    if (pins.dmack_n && slow != 8'h00) begin
      #20 pio_rdy = 1'h0;
      repeat (slow) @(posedge link_clk);
      pio_rdy = 1'h1;
    end
  end
  always @(posedge pins.diow_n) begin
    if (pins.dmack_n)
      wreg = dd_w;
    else if (!udma)
      cap.push_back(dd_w);
    else
      stopped = 1'h1;
  end
  always @(posedge pins.dmack_n) begin
    stopped = 1'h0;
    k = 16'h0000;
  end
  always @(pins.dior_n) begin
    if (!pins.dmack_n && !udma && pins.dior_n)
      k = k + 16'h0001;
    if (!pins.dmack_n && udma && !rd && !pins.diow_n)
      cap.push_back(dd_w);
  end
  // Strobe toggles while ready; a held strobe pauses the burst
  always @(posedge link_clk) begin
    if (udma && rd && !pins.dmack_n && !pins.diow_n && !pins.dior_n) begin
      ph <= ph + 3'h1;
      if (ph == 3'h3)
        dstb <= !dstb;
      if (ph == 3'h5)
        k <= k + 16'h0001;
    end
  end
  // Undriven bus shows a changing pattern
  always @(posedge link_clk) begin
    if (pins.dmack_n && !pins.dior_n && pins.cs_n != 2'h3)
      dev_dd <= {7'h2D, dev_num, 5'h00, pins.da};
    else if (!pins.dmack_n && rd)
      dev_dd <= 16'h3000 + k;
    else
      dev_dd <= ~dev_dd;
  end
endmodule

//--- bench/tb_atdp_host.sv
// Self-checking bench for the parallel disk host port
`timescale 1ns/1ps
module tb_atdp_host
  import atdp_pkg::*;
();
  logic        core_clk  = 1'h0;
  logic        link_clk  = 1'h0;
  logic        rstn      = 1'h0;
  logic        cmd_valid = 1'h0;
  atdp_cmd_s   cmd       = '0;
  logic        wr_valid  = 1'h0;
  logic [15:0] wr_data   = 16'h0000;
  logic        udma      = 1'h0;
  logic        rd        = 1'h0;
  logic        dreq      = 1'h0;
  logic [7:0]  slow      = 8'h00;
  logic        cmd_ready, done, done_timeout, wr_ready, rd_valid, iordy, dmarq;
  logic [15:0] done_rdata, rd_data, dev_dd, dd_w;
  atdp_pins_s  pins;
  int          error_cnt = 0;
  int          checked   = 0;
  int          wi = 0;
  int          wn = 0;
  int          ri = 0;
  int          cyc = 0;
  int          rlow = 0;
  ////////////////////////////////////////////////////////////////////////////
  initial forever #25 core_clk = ~core_clk;
  initial begin
    #7;
    forever #32 link_clk = ~link_clk;
  end
  assign dd_w = pins.dd_oe ? pins.dd : dev_dd;
  atdp_host #(.RESET_CYC(32'h8)) i_atdp_host (
    .core_clk(core_clk), .rstn(rstn), .link_clk(link_clk), .cmd_valid(cmd_valid), .cmd(cmd),
    .cmd_ready(cmd_ready), .done(done), .done_rdata(done_rdata), .done_timeout(done_timeout),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid),
    .rd_data(rd_data), .pins(pins), .iordy_i(iordy), .dmarq_i(dmarq), .dd_i(dd_w));
  atdp_dev_model i_atdp_dev_model (
    .link_clk(link_clk), .pins(pins), .dd_w(dd_w), .udma(udma), .rd(rd), .dreq(dreq),
    .slow(slow), .iordy(iordy), .dmarq(dmarq), .dev_dd(dev_dd));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    if (error_cnt == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(negedge core_clk) begin
    wr_valid = wi < wn;
    wr_data = 16'hC000 + 16'(wi);
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (wr_valid && wr_ready)
      wi <= wi + 1;
    if (rd_valid) begin
      check("rd_data", rd_data, 16'h3000 + 16'(ri));
      ri <= ri + 1;
    end
    if (cyc > 40000) begin
      error_cnt++;
      test_done();
    end
  end
  always @(posedge link_clk) begin
    if (!pins.reset_n)
      rlow <= rlow + 1;
  end
  task automatic run(input atdp_op_e op, input logic [2:0] md, input logic [15:0] ln);
    int n;
    @(negedge core_clk);
    wi = 0;
    ri = 0;
    wn = (op == OP_MW_WR || op == OP_UD_WR) ? int'(ln) : 0;
    cmd = '{op: op, mode: md, cs_n: 2'h2, addr: 3'h5, wdata: 16'h1234, len: ln};
    cmd_valid = 1'h1;
    @(negedge core_clk);
    cmd_valid = 1'h0;
    check("cmd_busy", 16'(cmd_ready), 16'h0000);
    n = 0;
    while (done !== 1'h1 && n < 6000) begin
      @(negedge core_clk);
      n++;
    end
    check("done", 16'(done), 16'h1);
    check("cmd_ready", 16'(cmd_ready), 16'h1);
  endtask
  task automatic t_pio;
    slow = 8'h06;
    run(OP_PIO_RD, 3'h0, 16'h1);
    check("pio_rd", done_rdata, 16'h5A05);
    check("pio_tmo", 16'(done_timeout), 16'h0);
    run(OP_PIO_WR, 3'h0, 16'h1);
    check("pio_wr", i_atdp_dev_model.wreg, 16'h1234);
    slow = 8'h28;
    run(OP_PIO_RD, 3'h0, 16'h1);
    check("pio_tmo", 16'(done_timeout), 16'h1);
    slow = 8'h00;
  endtask
  task automatic t_dma(input logic u, input logic r, input logic [2:0] md, input logic [15:0] ln);
    i_atdp_dev_model.cap.delete();
    udma = u;
    rd = r;
    dreq = 1'h1;
    run(r ? (u ? OP_UD_RD : OP_MW_RD) : (u ? OP_UD_WR : OP_MW_WR), md, ln);
    @(negedge core_clk);
    dreq = 1'h0;
    repeat (4) @(negedge core_clk);
    check("wr_ready", 16'(wr_ready), 16'h1);
    check("dma_rdata", done_rdata, 16'h0000);
    check("words", 16'(r ? ri : i_atdp_dev_model.cap.size()), ln);
    for (int i = 0; i < 16'(i_atdp_dev_model.cap.size()); i++)
      check("wr_word", i_atdp_dev_model.cap[i], 16'hC000 + 16'(i));
  endtask
  // Multiword burst in both directions
  task automatic t_mw;
    t_dma(1'h0, 1'h1, 3'h0, 16'h3);
    t_dma(1'h0, 1'h0, 3'h0, 16'h3);
  endtask
  // Ultra read, then writes in every mode
  task automatic t_udma;
    t_dma(1'h1, 1'h1, 3'h2, 16'h4);
    for (int m = 0; m < 5; m++)
      t_dma(1'h1, 1'h0, 3'(m), 16'h2);
  endtask
  task automatic t_rst;
    rlow = 0;
    run(OP_RESET, 3'h0, 16'h0);
    check("reset_len", 16'(rlow), 16'h0008);
    check("busy_set", 16'(i_atdp_dev_model.busy_cnt != 4'h0), 16'h1);
    repeat (24) @(negedge core_clk);
    check("busy_clr", 16'(i_atdp_dev_model.busy_cnt), 16'h0000);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    rstn = 1'h1;
    t_pio();
    t_mw();
    t_udma();
    t_rst();
    test_done();
  end
endmodule
